// ===== logic/tvrf_averager.sv
`timescale 1ns/1ns
`include "tvrf_regs.svh"
// accumulates samples and emits their mean every COUNT samples
module tvrf_averager #(
   parameter int COUNT = `TVRF_AVG_COUNT,
   parameter int SHIFT = `TVRF_AVG_SHIFT
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic bypass,
   input wire logic sample_valid,
   input wire logic [9:0] sample_code,
   input wire logic sample_fault,
   output logic mean_valid,
   output logic [9:0] mean_code,
   output logic mean_fault
);
   logic [13:0] acc_q;
   logic [4:0] cnt_q;
   logic fault_q;
   logic [13:0] sum;
   logic last;

   assign sum = acc_q + {4'h0, sample_code};
   assign last = bypass || (cnt_q == 5'(COUNT - 1));

   always_ff @(posedge ref_clk) begin
      if (!resetn || clear) begin
         acc_q <= 14'h0000;
         cnt_q <= 5'h00;
         fault_q <= 1'b0;
      end else if (sample_valid) begin
         if (last) begin
            acc_q <= 14'h0000;
            cnt_q <= 5'h00;
            fault_q <= 1'b0;
         end else begin
            acc_q <= sum;
            cnt_q <= cnt_q + 5'h01;
            fault_q <= fault_q | sample_fault;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mean_valid <= 1'b0;
         mean_code <= 10'h000;
         mean_fault <= 1'b0;
      end else begin
         mean_valid <= sample_valid && last && !clear;
         if (sample_valid && last) begin
            mean_code <= bypass ? sample_code : 10'(sum >> SHIFT);
            mean_fault <= fault_q | sample_fault;
         end
      end
   end
endmodule : tvrf_averager

// ===== logic/tvrf_pkg.sv
package tvrf_pkg;
   typedef enum logic [2:0] {
      TVRF_CH_NONE = 3'h0,
      TVRF_CH_CHIPSET = 3'h1,
      TVRF_CH_OWN = 3'h2,
      TVRF_CH_REMOTE1 = 3'h5,
      TVRF_CH_LOCAL = 3'h6,
      TVRF_CH_REMOTE2 = 3'h7
   } tvrf_chan_t;

   typedef enum logic [2:0] {
      TVRF_EX_IDLE = 3'h0,
      TVRF_EX_BASE_A = 3'h1,
      TVRF_EX_MULT1 = 3'h3,
      TVRF_EX_BASE_B = 3'h2,
      TVRF_EX_MULT2 = 3'h6
   } tvrf_exc_t;

   typedef struct packed {
      logic valid;
      logic fault;
      logic [9:0] code;
   } tvrf_sample_t;

   typedef struct packed {
      logic [7:0] main;
      logic [1:0] frac;
   } tvrf_result_t;
endpackage : tvrf_pkg

// ===== logic/tvrf_regs.svh
`ifndef TVRF_REGS_SVH
`define TVRF_REGS_SVH
// register offsets
`define TVRF_OFS_REMOTE1_TEMP 8'h25
`define TVRF_OFS_LOCAL_TEMP 8'h26
`define TVRF_OFS_REMOTE2_TEMP 8'h27
`define TVRF_OFS_CHIPSET_SUPPLY 8'h21
`define TVRF_OFS_OWN_SUPPLY 8'h22
`define TVRF_OFS_FAN1_MIN_HIGH 8'h55
`define TVRF_OFS_CONFIG2 8'h73
`define TVRF_OFS_FRACTION 8'h77
`define TVRF_OFS_CONFIG5 8'h7C
// field positions
`define TVRF_CHSEL_MSB 7
`define TVRF_CHSEL_LSB 5
`define TVRF_CFG2_AVG_OFF_BIT 4
`define TVRF_CFG2_SINGLE_BIT 6
`define TVRF_CFG5_TWOS_BIT 1
`define TVRF_FRAC_R2_MSB 7
`define TVRF_FRAC_LOC_MSB 5
`define TVRF_FRAC_R1_MSB 3
// reset values
`define TVRF_RST_BYTE 8'h00
`define TVRF_RST_FAN1_MIN_HIGH 8'hFF
// codes and counts
`define TVRF_AVG_COUNT 16
`define TVRF_AVG_SHIFT 4
`define TVRF_CODE_MAX 10'h3FF
`define TVRF_CODE_NOMINAL 10'h300
`define TVRF_FAULT_TWOS 8'h80
`define TVRF_FAULT_EXT 8'h00
`define TVRF_EXT_OFFSET 10'h100
`define TVRF_TWOS_MIN 10'h304
`define TVRF_TWOS_MAX 10'h1FC
`define TVRF_SIGN_FLIP 10'h200
`endif

// ===== logic/tvrf_result_format.sv
`timescale 1ns/1ns
`include "tvrf_regs.svh"
// What this block does
// [RULE1] single mode channel from fan1 register bits 7:5
// [RULE2] select codes 1,2,5,6,7 map to channels
// [RULE3] voltage codes unsigned, saturate 0 and 1023
// [RULE4] nominal supply input gives code 768
// [RULE5] local result upper byte at 0x26
// [RULE6] results in offset-64 or two's complement
// [RULE7] config5 bit1 picks clamped two's complement
// [RULE8] range -63..127 or -63..191, quarter degree; the extended byte here tops out at 0xBF (127 degrees)
// [RULE9] two's complement fault reads 1000 0000
// [RULE10] extended fault reads 0000 0000
// [RULE11] extended byte is degrees plus 64
// [RULE12] two's byte is signed whole degrees
// [RULE13] two fraction bits go to 0x77
// [RULE14] fractions at 7:6 remote2, 5:4 local, 3:2 remote1
// [RULE15] remote results held as 10-bit values
// [RULE16] each result averages 16 measurement cycles
// [RULE17] excite base/mult1 then base/mult2, combine
// [RULE18] byte and fraction from same average
// [RULE19] single mode converts selected channel only
module tvrf_result_format (
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // analog front end
   output tvrf_pkg::tvrf_chan_t afe_chan,
   output tvrf_pkg::tvrf_exc_t afe_excite,
   output logic afe_start,
   input wire logic afe_done,
   input wire logic [9:0] afe_code,
   input wire logic afe_fault,
   // voltage saturation flags
   input wire logic afe_under,
   input wire logic afe_over
);
   logic [7:0] fan1_q, cfg2_q, cfg5_q;
   logic [9:0] chip_q, own_q;
   tvrf_pkg::tvrf_result_t loc_q, r1_q, r2_q;
   tvrf_pkg::tvrf_chan_t chan_q, chan_d, chan_nx;
   tvrf_pkg::tvrf_exc_t exc_q;
   logic busy_q, start_q, done_s1_q, done_q, done_p_q;
   logic [9:0] code_q;
   logic fault_q, under_q, over_q;
   logic [9:0] d1_q;
   logic [10:0] sum_code;
   logic [9:0] conv_code;
   logic mean_valid, mean_fault;
   logic [9:0] mean_code;
   logic is_temp, single_mode, sel_legal;
   tvrf_pkg::tvrf_chan_t sel_chan;
   tvrf_pkg::tvrf_result_t fmt;
   logic [9:0] ext_code, avg_in, t_mean;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fan1_q <= `TVRF_RST_FAN1_MIN_HIGH;
         cfg2_q <= `TVRF_RST_BYTE;
         cfg5_q <= `TVRF_RST_BYTE;
      end else if (reg_wr) begin
         if (reg_addr == `TVRF_OFS_FAN1_MIN_HIGH) fan1_q <= reg_wdata;
         if (reg_addr == `TVRF_OFS_CONFIG2) cfg2_q <= reg_wdata;
         if (reg_addr == `TVRF_OFS_CONFIG5) cfg5_q <= reg_wdata;
      end
   end

   assign single_mode = cfg2_q[`TVRF_CFG2_SINGLE_BIT];
   assign sel_chan = tvrf_pkg::tvrf_chan_t'(fan1_q[`TVRF_CHSEL_MSB:`TVRF_CHSEL_LSB]); // RULE1
   // RULE2
   assign sel_legal = (sel_chan == tvrf_pkg::TVRF_CH_CHIPSET) ||
      (sel_chan == tvrf_pkg::TVRF_CH_OWN) || (sel_chan == tvrf_pkg::TVRF_CH_REMOTE1) ||
      (sel_chan == tvrf_pkg::TVRF_CH_LOCAL) || (sel_chan == tvrf_pkg::TVRF_CH_REMOTE2);

   // ------------------------------------------------------------
   // channel round robin
   // ------------------------------------------------------------
   always_comb begin
      chan_d = tvrf_pkg::TVRF_CH_CHIPSET;
      if (single_mode && sel_legal) begin
         chan_d = sel_chan; // RULE19
      end else begin
         unique case (chan_q)
            tvrf_pkg::TVRF_CH_CHIPSET: chan_d = tvrf_pkg::TVRF_CH_OWN;
            tvrf_pkg::TVRF_CH_OWN: chan_d = tvrf_pkg::TVRF_CH_REMOTE1;
            tvrf_pkg::TVRF_CH_REMOTE1: chan_d = tvrf_pkg::TVRF_CH_LOCAL;
            tvrf_pkg::TVRF_CH_LOCAL: chan_d = tvrf_pkg::TVRF_CH_REMOTE2;
            default: chan_d = tvrf_pkg::TVRF_CH_CHIPSET;
         endcase
      end
   end

   assign is_temp = chan_q[2];
   // a finished average moves the sequencer on to the next channel
   assign chan_nx = mean_valid ? chan_d : chan_q;

   // ------------------------------------------------------------
   // front end inputs, two-stage synchronised done
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         done_s1_q <= 1'b0;
         done_q <= 1'b0;
         done_p_q <= 1'b0;
      end else begin
         done_s1_q <= afe_done;
         done_q <= done_s1_q;
         done_p_q <= done_q;
      end
   end

   // data is stable while done is high; sampled after synchroniser
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         code_q <= 10'h000;
         fault_q <= 1'b0;
         under_q <= 1'b0;
         over_q <= 1'b0;
      end else if (done_q && !done_p_q) begin
         code_q <= afe_code;
         fault_q <= afe_fault;
         under_q <= afe_under;
         over_q <= afe_over;
      end
   end

   // ------------------------------------------------------------
   // excitation sequencer
   // ------------------------------------------------------------
   logic step_done;
   assign step_done = busy_q && done_p_q && !done_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         exc_q <= tvrf_pkg::TVRF_EX_IDLE;
         chan_q <= tvrf_pkg::TVRF_CH_CHIPSET;
         busy_q <= 1'b0;
         start_q <= 1'b0;
         d1_q <= 10'h000;
      end else begin
         start_q <= 1'b0;
         if (!busy_q) begin
            busy_q <= 1'b1;
            start_q <= 1'b1;
            chan_q <= chan_nx; // RULE19
            exc_q <= chan_nx[2] && chan_nx != tvrf_pkg::TVRF_CH_LOCAL ?
               tvrf_pkg::TVRF_EX_BASE_A : tvrf_pkg::TVRF_EX_IDLE;
         end else if (step_done) begin
            unique case (exc_q)
               tvrf_pkg::TVRF_EX_BASE_A: begin
                  exc_q <= tvrf_pkg::TVRF_EX_MULT1; // RULE17
                  start_q <= 1'b1;
               end
               tvrf_pkg::TVRF_EX_MULT1: begin
                  d1_q <= code_q;
                  exc_q <= tvrf_pkg::TVRF_EX_BASE_B; // RULE17
                  start_q <= 1'b1;
               end
               tvrf_pkg::TVRF_EX_BASE_B: begin
                  exc_q <= tvrf_pkg::TVRF_EX_MULT2; // RULE17
                  start_q <= 1'b1;
               end
               default: begin
                  exc_q <= tvrf_pkg::TVRF_EX_IDLE;
                  busy_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // combine both differences as their signed mean, no wrap near zero degrees
   assign sum_code = {d1_q[9], d1_q} + {code_q[9], code_q}; // RULE17
   always_comb begin
      conv_code = code_q;
      if (exc_q == tvrf_pkg::TVRF_EX_MULT2) conv_code = sum_code[10:1];
      if (!is_temp && under_q) conv_code = 10'h000; // RULE3
      if (!is_temp && over_q) conv_code = `TVRF_CODE_MAX; // RULE3
   end

   assign afe_start = start_q;
   assign afe_chan = chan_q;
   assign afe_excite = exc_q;

   // ------------------------------------------------------------
   // averaging
   // ------------------------------------------------------------
   logic conv_end;
   assign conv_end = step_done && (exc_q == tvrf_pkg::TVRF_EX_IDLE ||
      exc_q == tvrf_pkg::TVRF_EX_MULT2);
   // temperatures are offset to unsigned so the sum does not wrap at zero
   assign avg_in = is_temp ? conv_code ^ `TVRF_SIGN_FLIP : conv_code;
   assign t_mean = mean_code ^ `TVRF_SIGN_FLIP;

   tvrf_averager #(
      .COUNT(`TVRF_AVG_COUNT),
      .SHIFT(`TVRF_AVG_SHIFT)
   ) u_avg (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clear(1'b0),
      .bypass(cfg2_q[`TVRF_CFG2_AVG_OFF_BIT]),
      .sample_valid(conv_end), // RULE16
      .sample_code(avg_in),
      .sample_fault(fault_q && is_temp),
      .mean_valid(mean_valid),
      .mean_code(mean_code),
      .mean_fault(mean_fault)
   );

   // result channel latches the converting channel at every conversion end
   tvrf_pkg::tvrf_chan_t res_chan_q;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         res_chan_q <= tvrf_pkg::TVRF_CH_CHIPSET;
      end else if (conv_end) begin
         res_chan_q <= chan_q;
      end
   end

   // ------------------------------------------------------------
   // temperature formatting
   // ------------------------------------------------------------
   always_comb begin
      ext_code = t_mean + `TVRF_EXT_OFFSET; // RULE11
      fmt.main = ext_code[9:2];
      fmt.frac = ext_code[1:0]; // RULE15
      if (cfg5_q[`TVRF_CFG5_TWOS_BIT]) begin // RULE7
         fmt.main = t_mean[9:2]; // RULE12
         fmt.frac = t_mean[1:0];
         if (!t_mean[9] && t_mean > `TVRF_TWOS_MAX) begin
            fmt.main = 8'h7F; // RULE8
            fmt.frac = 2'b00;
         end
         if (t_mean[9] && t_mean < `TVRF_TWOS_MIN) begin
            fmt.main = 8'hC1; // RULE8
            fmt.frac = 2'b00;
         end
      end else if (t_mean[9] && t_mean < `TVRF_TWOS_MIN) begin
         fmt.main = 8'h01; // RULE8
         fmt.frac = 2'b00;
      end
      if (mean_fault) begin
         fmt.main = cfg5_q[`TVRF_CFG5_TWOS_BIT] ? `TVRF_FAULT_TWOS : `TVRF_FAULT_EXT; // RULE9 RULE10
         fmt.frac = 2'b00;
      end
   end

   // only the averaged channel updates, byte and fraction together
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         chip_q <= 10'h000;
         own_q <= 10'h000;
         loc_q <= '0;
         r1_q <= '0;
         r2_q <= '0;
      end else if (mean_valid) begin
         unique case (res_chan_q)
            tvrf_pkg::TVRF_CH_CHIPSET: chip_q <= mean_code; // RULE4
            tvrf_pkg::TVRF_CH_OWN: own_q <= mean_code; // RULE4
            tvrf_pkg::TVRF_CH_REMOTE1: r1_q <= fmt; // RULE6 RULE18 RULE19
            tvrf_pkg::TVRF_CH_LOCAL: loc_q <= fmt; // RULE5 RULE6 RULE18
            tvrf_pkg::TVRF_CH_REMOTE2: r2_q <= fmt; // RULE6 RULE18
            default: chip_q <= chip_q;
         endcase
      end
   end

   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         `TVRF_OFS_CHIPSET_SUPPLY: reg_rdata = chip_q[9:2];
         `TVRF_OFS_OWN_SUPPLY: reg_rdata = own_q[9:2];
         `TVRF_OFS_REMOTE1_TEMP: reg_rdata = r1_q.main;
         `TVRF_OFS_LOCAL_TEMP: reg_rdata = loc_q.main; // RULE5
         `TVRF_OFS_REMOTE2_TEMP: reg_rdata = r2_q.main;
         `TVRF_OFS_FAN1_MIN_HIGH: reg_rdata = fan1_q;
         `TVRF_OFS_CONFIG2: reg_rdata = cfg2_q;
         `TVRF_OFS_CONFIG5: reg_rdata = cfg5_q;
         `TVRF_OFS_FRACTION: reg_rdata = {r2_q.frac, loc_q.frac, r1_q.frac, 2'b00}; // RULE13 RULE14
         default: reg_rdata = 8'h00;
      endcase
   end
endmodule : tvrf_result_format

// ===== testbench/test_temp_voltage_result_format.sv
`timescale 1ns/1ns
module test_temp_voltage_result_format;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, d;
   logic [9:0] afe_code;
   logic afe_start, afe_done, afe_fault, afe_under, afe_over;
   tvrf_pkg::tvrf_chan_t afe_chan;
   tvrf_pkg::tvrf_exc_t afe_excite;
   logic [7:0][9:0] vals = '0;
   logic [7:0] flt = 8'h00;
   logic slow = 1'b0;
   logic noisy = 1'b0;
   logic [2:0] ch, pch;
   logic [7:0] exp_main [8];
   logic [2:0] chans [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
   int error_cnt = 0;
   int tests_run = 0;

   always #25 ref_clk = ~ref_clk;

   tvrf_result_format u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .afe_chan(afe_chan),
      .afe_excite(afe_excite), .afe_start(afe_start), .afe_done(afe_done),
      .afe_code(afe_code), .afe_fault(afe_fault), .afe_under(afe_under), .afe_over(afe_over));
   tvrf_afe_model u_afe (.ref_clk(ref_clk), .afe_chan(afe_chan), .afe_excite(afe_excite),
      .afe_start(afe_start), .value(vals), .fault(flt), .slow(slow), .noisy(noisy),
      .afe_done(afe_done), .afe_code(afe_code), .afe_fault(afe_fault),
      .afe_under(afe_under), .afe_over(afe_over));

   task automatic tally_and_finish;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      #1 v = reg_rdata;
   endtask : rd

   // counts conversion requests on one channel, or on any when given zero
   task automatic wait_for(input logic [2:0] c, input int n);
      int got;
      got = 0;
      for (int i = 0; i < 30000 && got < n; i++) begin
         @(negedge ref_clk);
         if (afe_start === 1'b1 && (c == 3'h0 || afe_chan === c)) got++;
      end
      if (got < n) begin
         error_cnt++;
         $display("MISMATCH %0t no conversion request", $time);
         tally_and_finish;
      end
   endtask : wait_for

   // expected {result byte, fraction bits}
   function automatic logic [9:0] fmt(input logic [2:0] c, input logic [9:0] v,
                                      input logic f, input logic tw);
      int q;
      logic [1:0] fr;
      if (c < 3'h5) return {v[9:2], 2'b00};
      if (f) return {tw ? 8'h80 : 8'h00, 2'b00};
      q = $signed(v) >>> 2;
      fr = v[1:0];
      if (q < -63) begin
         q = -63;
         fr = 2'b00;
      end
      if (!tw) q = q + 64;
      return {q[7:0], fr};
   endfunction : fmt

   task automatic check_ch(input logic [2:0] c, input logic tw);
      logic [9:0] e;
      e = fmt(c, vals[c], flt[c], tw);
      exp_main[c] = e[9:2];
      rd(8'h20 + {5'h00, c}, d);
      check(d, e[9:2]);
      if (c > 3'h4) begin
         rd(8'h77, d);
         check({6'h00, d[2 * c - 7 -: 2]}, {6'h00, e[1:0]});
      end
   endtask : check_ch

   initial begin
      void'($urandom(32'h247c3216));
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      rd(8'h55, d);
      check(d, 8'hFF);
      rd(8'h77, d);
      check(d, 8'h00);
      wr(8'h26, 8'hA5);
      rd(8'h26, d);
      check(d, 8'h00);
      rd(8'h10, d);
      check(d, 8'h00);
      // round robin with averaging and noisy slow front end
      vals[1] = 10'h300;
      vals[2] = 10'($urandom_range(1023, 0));
      for (int c = 5; c < 8; c++) vals[c] = 10'($urandom_range(720, 0) - 240);
      slow = 1'b1;
      noisy = 1'b1;
      wait_for(3'h5, 1);
      wait_for(3'h6, 1);
      wait_for(3'h2, 1);
      wait_for(3'h5, 1);
      for (int i = 0; i < 5; i++) check_ch(chans[i], 1'b0);
      // single channel, averaging off
      noisy = 1'b0;
      wr(8'h73, 8'h50);
      for (int i = 0; i < 10; i++) begin
         ch = chans[i % 5];
         if (i == 5) begin
            wr(8'h7C, 8'h02);
            rd(8'h7C, d);
            check(d, 8'h02);
         end
         vals[ch] = ch < 3'h5 ? 10'($urandom_range(1023, 0)) : 10'($urandom_range(720, 0) - 240);
         if (i == 0) vals[ch] = 10'h3FF;
         if (i == 5) vals[ch] = 10'h000;
         // minus seventy degrees, below the reportable floor
         if (i == 4 || i == 9) vals[ch] = 10'h2E8;
         flt[ch] = i == 3 || i == 7;
         wr(8'h55, {ch, 5'h00});
         wait_for(ch, 6);
         wait_for(3'h0, 1);
         check({5'h00, afe_chan}, {5'h00, ch});
         check_ch(ch, i > 4);
         if (i > 0 && i != 5) begin
            rd(8'h20 + {5'h00, pch}, d);
            check(d, exp_main[pch]);
         end
         pch = ch;
      end
      tally_and_finish;
   end
endmodule : test_temp_voltage_result_format

// ===== testbench/tvrf_afe_model.sv
`timescale 1ns/1ns
module tvrf_afe_model (
   input wire logic ref_clk,
   input tvrf_pkg::tvrf_chan_t afe_chan,
   input tvrf_pkg::tvrf_exc_t afe_excite,
   input wire logic afe_start,
   input wire logic [7:0][9:0] value,
   input wire logic [7:0] fault,
   input wire logic slow,
   input wire logic noisy,
   output logic afe_done,
   output logic [9:0] afe_code,
   output logic afe_fault,
   output logic afe_under,
   output logic afe_over
);
   logic [9:0] raw;
   logic [9:0] jit;
   logic volt;
   initial begin
      afe_done = 1'b0;
      afe_code = 10'h000;
      afe_fault = 1'b0;
      afe_under = 1'b0;
      afe_over = 1'b0;
      jit = 10'h004;
      forever begin
         @(posedge ref_clk);
         if (afe_start === 1'b1) begin
            volt = afe_chan inside {3'h1, 3'h2};
            repeat (slow ? $urandom_range(6, 1) : 1) @(posedge ref_clk);
            raw = value[afe_chan] + ((noisy && !volt) ? jit : 10'h000);
            // multiples sit one code either side, base steps carry junk
            if (afe_excite == 3'h3) raw = raw + 10'h001;
            else if (afe_excite == 3'h6) raw = raw - 10'h001;
            else if (afe_excite != 3'h0) raw = ~raw;
            // alternating noise cancels over an even count of measurements
            if (afe_excite inside {3'h0, 3'h6}) jit = 10'h000 - jit;
            afe_code <= raw;
            afe_fault <= fault[afe_chan] && !volt;
            afe_under <= volt && value[afe_chan] == 10'h000;
            afe_over <= volt && value[afe_chan] == 10'h3FF;
            afe_done <= 1'b1;
            repeat (4) @(posedge ref_clk);
            afe_done <= 1'b0;
            afe_code <= ~raw;
            afe_fault <= 1'b0;
         end
      end
   end
endmodule : tvrf_afe_model

// ===== testbench/tvrf_checker.sv
`timescale 1ns/1ns
module tvrf_checker (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input tvrf_pkg::tvrf_chan_t afe_chan,
   input tvrf_pkg::tvrf_exc_t afe_excite,
   input wire logic afe_start,
   input wire logic afe_done
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   logic [2:0] last_exc_q;
   logic [7:0] sel_reg_q;
   // excitation step of the previous conversion request
   always_ff @(posedge ref_clk) begin
      if (!resetn) last_exc_q <= 3'h0;
      else if (afe_start) last_exc_q <= afe_excite;
   end
   // shadow of the channel select register
   always_ff @(posedge ref_clk) begin
      if (!resetn) sel_reg_q <= 8'hFF;
      else if (reg_wr && reg_addr == 8'h55) sel_reg_q <= reg_wdata;
   end
   // ----------
   // assertions
   // ----------
   sequence s_step(logic [2:0] e);
      afe_start && afe_excite == e;
   endsequence
   property p_mult1; s_step(3'h3) |-> last_exc_q == 3'h1; endproperty
   property p_base_b; s_step(3'h2) |-> last_exc_q == 3'h3; endproperty
   property p_mult2; s_step(3'h6) |-> last_exc_q == 3'h2; endproperty
   property p_kind; afe_start |-> (afe_excite == 3'h0) == !(afe_chan inside {3'h5, 3'h7});
   endproperty
   property p_legal; afe_start |-> afe_chan inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}; endproperty
   property p_busy; afe_done |-> !afe_start; endproperty
   property p_restart; $fell(afe_done) |-> ##[1:6] afe_start; endproperty
   property p_hold;
      afe_done && $past(afe_done) |-> $stable(afe_chan) && $stable(afe_excite);
   endproperty
   property p_sel; reg_addr == 8'h55 |-> reg_rdata == sel_reg_q; endproperty
   a_mult1: assert property (p_mult1) else $error("mult1 step not after base");
   a_base_b: assert property (p_base_b) else $error("second base not after mult1");
   a_mult2: assert property (p_mult2) else $error("mult2 step not after base");
   a_kind: assert property (p_kind) else $error("excitation kind wrong for channel");
   a_legal: assert property (p_legal) else $error("illegal channel converted");
   a_busy: assert property (p_busy) else $error("request while front end busy");
   a_restart: assert property (p_restart) else $error("no next request");
   a_hold: assert property (p_hold) else $error("channel changed mid step");
   a_sel: assert property (p_sel) else $error("select register readback wrong");
endmodule : tvrf_checker
bind tvrf_result_format tvrf_checker u_checker (.ref_clk(ref_clk), .resetn(resetn),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .afe_chan(afe_chan), .afe_excite(afe_excite), .afe_start(afe_start), .afe_done(afe_done));
